// File: hdl/usdp_top.sv
// Shadow receive/transmit data window of a serial port, with FIFOs and interrupts
//
// The plain strobed port is this design's own decision.
`timescale 1ns/1ps
`include "usdp_params.svh"

// Operation
// - Without FIFOs a window read gives last received byte in bits 7:0; bits 31:8 read zero.
// - Sixteen consecutive word addresses all alias the same data window.
// - Read data is valid only while the byte-available flag is set.
// - Without FIFOs a new byte overwrites an unread one and flags overrun.
// - With FIFOs a window read returns the oldest receive FIFO entry.
// - Full receive FIFO not read in the same cycle keeps contents, drops new byte, flags overrun.
// - Written byte goes out on serial line, or infrared line in infrared mode.
// - Without FIFOs one write clears the transmit-holding-empty flag.
// - Without FIFOs further writes replace the pending holding byte.
// - With FIFOs up to sixteen bytes may be written before full.
// - Writes while the transmit FIFO is full are discarded.
module usdp_top import usdp_pkg::*; (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  // Received characters from the serial and infrared receivers
  input  wire logic        uart_rx_valid,
  input  wire usdp_byte_t  uart_rx_data,
  input  wire logic        ir_rx_valid,
  input  wire usdp_byte_t  ir_rx_data,
  // Characters to the serial and infrared transmitters
  output usdp_byte_t       tx_data,
  output logic             uart_tx_valid,
  output logic             ir_tx_valid,
  input  wire logic        tx_ready,
  // Line flags for neighbouring logic
  output logic             rx_byte_available,
  output logic             tx_holding_empty,
  output logic             fifo_enable,
  output logic             ir_mode,
  // Interrupt
  output logic             irq
);

  function automatic logic in_window(input logic [31:0] a);
    return (a >= `USDP_WIN_BASE) && (a <= `USDP_WIN_LAST) && (a[1:0] == 2'h0);
  endfunction

  function automatic usdp_ptr_t ptr_inc(input usdp_ptr_t p);
    return p + 4'h1;
  endfunction

  function automatic usdp_cnt_t cnt_step(input usdp_cnt_t c, input logic inc, input logic dec);
    usdp_cnt_t r;
    r = c;
    if (inc && !dec) begin
      r = c + 5'h01;
    end else if (dec && !inc) begin
      r = c - 5'h01;
    end
    return r;
  endfunction

  // Address decode
  logic win_wr;
  logic win_rd;
  logic ctrl_wr;
  logic line_rd;
  logic iclr_wr;
  logic ien_wr;

  assign win_wr  = bus_wr && in_window(bus_addr);
  assign win_rd  = bus_rd && in_window(bus_addr);
  assign ctrl_wr = bus_wr && (bus_addr == `USDP_OFS_CTRL);
  assign line_rd = bus_rd && (bus_addr == `USDP_OFS_LINE);
  assign iclr_wr = bus_wr && (bus_addr == `USDP_OFS_ICLR);
  assign ien_wr  = bus_wr && (bus_addr == `USDP_OFS_IEN);

  // Control and enable registers
  logic [1:0] ctrl_q;
  logic [1:0] ctrl_d;
  usdp_irq_t  ien_q;
  usdp_irq_t  ien_d;
  logic       flush;

  always_comb begin
    ctrl_d = ctrl_q;
    ien_d  = ien_q;
    if (ctrl_wr) begin
      ctrl_d = bus_wdata[1:0];
    end
    if (ien_wr) begin
      ien_d = bus_wdata[2:0];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= `USDP_CTRL_RESET;
      ien_q  <= `USDP_IRQ_RESET;
    end else begin
      ctrl_q <= ctrl_d;
      ien_q  <= ien_d;
    end
  end

  assign fifo_enable = ctrl_q[`USDP_CTRL_FIFO_EN];
  assign ir_mode     = ctrl_q[`USDP_CTRL_IR_MODE];
  // Switching FIFO mode empties both directions so stale bytes never mix modes
  assign flush = ctrl_wr && (bus_wdata[`USDP_CTRL_FIFO_EN] != fifo_enable);

  // Receive path
  usdp_mem_if rx_mem ();
  usdp_mem_if tx_mem ();

  logic       rx_in_valid;
  usdp_byte_t rx_in_data;
  usdp_ptr_t  rx_wp_q;
  usdp_ptr_t  rx_wp_d;
  usdp_ptr_t  rx_rp_q;
  usdp_ptr_t  rx_rp_d;
  usdp_cnt_t  rx_cnt_q;
  usdp_cnt_t  rx_cnt_d;
  usdp_byte_t rx_hold_q;
  usdp_byte_t rx_hold_d;
  logic       rx_full_q;
  logic       rx_full_d;
  logic       rx_push;
  logic       rx_pop;
  logic       rx_ev;
  logic       ovr_ev;

  assign rx_in_valid = ir_mode ? ir_rx_valid : uart_rx_valid;
  assign rx_in_data  = ir_mode ? ir_rx_data : uart_rx_data;

  always_comb begin
    rx_wp_d   = rx_wp_q;
    rx_rp_d   = rx_rp_q;
    rx_cnt_d  = rx_cnt_q;
    rx_hold_d = rx_hold_q;
    rx_full_d = rx_full_q;
    rx_push   = 1'b0;
    rx_pop    = 1'b0;
    rx_ev     = 1'b0;
    ovr_ev    = 1'b0;
    if (flush) begin
      rx_wp_d   = 4'h0;
      rx_rp_d   = 4'h0;
      rx_cnt_d  = 5'h00;
      rx_full_d = 1'b0;
    end else if (fifo_enable) begin
      rx_pop  = win_rd && (rx_cnt_q != 5'h00);
      // A pop in the same cycle frees the slot the new byte needs
      rx_push = rx_in_valid && ((rx_cnt_q != `USDP_FIFO_DEPTH) || rx_pop);
      ovr_ev  = rx_in_valid && !rx_push;
      rx_ev   = rx_push;
      if (rx_push) begin
        rx_wp_d = ptr_inc(rx_wp_q);
      end
      if (rx_pop) begin
        rx_rp_d = ptr_inc(rx_rp_q);
      end
      rx_cnt_d = cnt_step(rx_cnt_q, rx_push, rx_pop);
    end else begin
      if (win_rd) begin
        rx_full_d = 1'b0;
      end
      if (rx_in_valid) begin
        rx_hold_d = rx_in_data;
        rx_full_d = 1'b1;
        rx_ev     = 1'b1;
        ovr_ev    = rx_full_q && !win_rd;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rx_wp_q   <= 4'h0;
      rx_rp_q   <= 4'h0;
      rx_cnt_q  <= 5'h00;
      rx_hold_q <= `USDP_WIN_RESET;
      rx_full_q <= 1'b0;
    end else begin
      rx_wp_q   <= rx_wp_d;
      rx_rp_q   <= rx_rp_d;
      rx_cnt_q  <= rx_cnt_d;
      rx_hold_q <= rx_hold_d;
      rx_full_q <= rx_full_d;
    end
  end

  assign rx_mem.we    = rx_push;
  assign rx_mem.waddr = rx_wp_q;
  assign rx_mem.wdata = rx_in_data;
  assign rx_mem.raddr = rx_rp_q;

  usdp_fifo_mem u_rx_mem (
    .clk  (clk),
    .srst (srst),
    .mp   (rx_mem)
  );

  assign rx_byte_available = fifo_enable ? (rx_cnt_q != 5'h00) : rx_full_q;

  // Transmit path
  usdp_ptr_t  tx_wp_q;
  usdp_ptr_t  tx_wp_d;
  usdp_ptr_t  tx_rp_q;
  usdp_ptr_t  tx_rp_d;
  usdp_cnt_t  tx_cnt_q;
  usdp_cnt_t  tx_cnt_d;
  usdp_byte_t thr_q;
  usdp_byte_t thr_d;
  logic       thr_full_q;
  logic       thr_full_d;
  logic       tx_stale_q;
  logic       tx_stale_d;
  logic       tx_push;
  logic       tx_any;
  logic       tx_take;

  // Head byte of the FIFO is one read cycle behind a take or a push into an empty FIFO
  assign tx_any  = fifo_enable ? ((tx_cnt_q != 5'h00) && !tx_stale_q) : thr_full_q;
  assign tx_take = tx_any && tx_ready;

  always_comb begin
    tx_wp_d    = tx_wp_q;
    tx_rp_d    = tx_rp_q;
    tx_cnt_d   = tx_cnt_q;
    thr_d      = thr_q;
    thr_full_d = thr_full_q;
    tx_stale_d = 1'b0;
    tx_push    = 1'b0;
    if (flush) begin
      tx_wp_d    = 4'h0;
      tx_rp_d    = 4'h0;
      tx_cnt_d   = 5'h00;
      thr_full_d = 1'b0;
    end else if (fifo_enable) begin
      tx_push = win_wr && (tx_cnt_q != `USDP_FIFO_DEPTH);
      if (tx_push) begin
        tx_wp_d = ptr_inc(tx_wp_q);
      end
      if (tx_take) begin
        tx_rp_d = ptr_inc(tx_rp_q);
      end
      tx_cnt_d   = cnt_step(tx_cnt_q, tx_push, tx_take);
      tx_stale_d = tx_take || (tx_push && (tx_cnt_q == 5'h00));
    end else begin
      if (tx_take) begin
        thr_full_d = 1'b0;
      end
      if (win_wr) begin
        thr_d      = bus_wdata[7:0];
        thr_full_d = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tx_wp_q    <= 4'h0;
      tx_rp_q    <= 4'h0;
      tx_cnt_q   <= 5'h00;
      thr_q      <= `USDP_WIN_RESET;
      thr_full_q <= 1'b0;
      tx_stale_q <= 1'b0;
    end else begin
      tx_wp_q    <= tx_wp_d;
      tx_rp_q    <= tx_rp_d;
      tx_cnt_q   <= tx_cnt_d;
      thr_q      <= thr_d;
      thr_full_q <= thr_full_d;
      tx_stale_q <= tx_stale_d;
    end
  end

  assign tx_mem.we    = tx_push;
  assign tx_mem.waddr = tx_wp_q;
  assign tx_mem.wdata = bus_wdata[7:0];
  assign tx_mem.raddr = tx_rp_q;

  usdp_fifo_mem u_tx_mem (
    .clk  (clk),
    .srst (srst),
    .mp   (tx_mem)
  );

  assign tx_data       = fifo_enable ? tx_mem.rdata : thr_q;
  // The infrared encoder turns this into its active-low output pulse
  assign uart_tx_valid = tx_any && !ir_mode;
  assign ir_tx_valid   = tx_any && ir_mode;
  assign tx_holding_empty = fifo_enable ? (tx_cnt_q == 5'h00) : !thr_full_q;

  // Overrun flag and interrupts; a set in the clearing cycle wins
  logic      ovr_q;
  logic      ovr_d;
  logic      tx_holding_empty_prev_q;
  usdp_irq_t ist_q;
  usdp_irq_t ist_d;
  usdp_irq_t ev;

  always_comb begin
    ev                 = 3'h0;
    ev[`USDP_IRQ_RX]   = rx_ev;
    ev[`USDP_IRQ_OVR]  = ovr_ev;
    ev[`USDP_IRQ_TX_HOLDING_EMPTY] = tx_holding_empty && !tx_holding_empty_prev_q;
    ist_d = ist_q;
    if (iclr_wr) begin
      ist_d = ist_q & ~bus_wdata[2:0];
    end
    ist_d = ist_d | ev;
    ovr_d = (ovr_q && !line_rd) || ovr_ev;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ovr_q       <= 1'b0;
      tx_holding_empty_prev_q <= 1'b1;
      ist_q       <= `USDP_IRQ_RESET;
    end else begin
      ovr_q       <= ovr_d;
      tx_holding_empty_prev_q <= tx_holding_empty;
      ist_q       <= ist_d;
    end
  end

  assign irq = |(ist_q & ien_q);

  // Read data, one cycle after the strobe
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic        win_mem_q;
  logic        win_mem_d;

  always_comb begin
    rdata_d   = 32'h0000_0000;
    win_mem_d = win_rd && fifo_enable;
    if (win_rd && !fifo_enable) begin
      rdata_d[7:0] = rx_hold_q;
    end else if (bus_rd) begin
      case (bus_addr)
        `USDP_OFS_CTRL: begin
          rdata_d[1:0] = ctrl_q;
        end
        `USDP_OFS_LINE: begin
          rdata_d[`USDP_LINE_AVAIL]   = rx_byte_available;
          rdata_d[`USDP_LINE_OVERRUN] = ovr_q;
          rdata_d[`USDP_LINE_TX_HOLDING_EMPTY]    = tx_holding_empty;
        end
        `USDP_OFS_IST: begin
          rdata_d[2:0] = ist_q;
        end
        `USDP_OFS_IEN: begin
          rdata_d[2:0] = ien_q;
        end
        default: begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q   <= 32'h0000_0000;
      win_mem_q <= 1'b0;
    end else begin
      rdata_q   <= rdata_d;
      win_mem_q <= win_mem_d;
    end
  end

  // Upper window bits stay zero in both modes
  assign bus_rdata = win_mem_q ? {24'h00_0000, rx_mem.rdata} : rdata_q;

endmodule

// File: hdl/usdp_params.svh
// Register map, field positions and reset values of the shadow data port
`ifndef USDP_PARAMS_SVH
`define USDP_PARAMS_SVH

// Sixteen aliased word locations of the data window
`define USDP_WIN_BASE      32'h5000_1130
`define USDP_WIN_LAST      32'h5000_116C
`define USDP_OFS_WIN12     32'h5000_1160

// Supporting registers
`define USDP_OFS_CTRL      32'h5000_1180
`define USDP_OFS_LINE      32'h5000_1184
`define USDP_OFS_IST       32'h5000_1188
`define USDP_OFS_ICLR      32'h5000_118C
`define USDP_OFS_IEN       32'h5000_1190

// Control fields
`define USDP_CTRL_FIFO_EN  0
`define USDP_CTRL_IR_MODE  1
`define USDP_CTRL_RESET    2'h0

// Line status fields
`define USDP_LINE_AVAIL    0
`define USDP_LINE_OVERRUN  1
`define USDP_LINE_TX_HOLDING_EMPTY     5

// Interrupt fields
`define USDP_IRQ_RX        0
`define USDP_IRQ_OVR       1
`define USDP_IRQ_TX_HOLDING_EMPTY      2
`define USDP_IRQ_RESET     3'h0

// Window and FIFO
`define USDP_WIN_RESET     8'h00
`define USDP_FIFO_DEPTH    5'h10

`endif

// File: hdl/usdp_pkg.sv
// Types shared by the shadow data port modules
package usdp_pkg;
  typedef logic [7:0] usdp_byte_t;
  typedef logic [3:0] usdp_ptr_t;
  typedef logic [4:0] usdp_cnt_t;
  typedef logic [2:0] usdp_irq_t;
endpackage

// File: hdl/usdp_mem_if.sv
// Port bundle between a FIFO owner and its storage
`timescale 1ns/1ps
interface usdp_mem_if import usdp_pkg::*; ();
  logic       we;
  usdp_ptr_t  waddr;
  usdp_byte_t wdata;
  usdp_ptr_t  raddr;
  usdp_byte_t rdata;

  modport owner (output we, output waddr, output wdata, output raddr, input rdata);
  modport store (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// File: hdl/usdp_fifo_mem.sv
// Sixteen-byte storage with registered read data
`timescale 1ns/1ps
module usdp_fifo_mem import usdp_pkg::*; (
  // Clock and reset
  input wire logic   clk,
  input wire logic   srst,
  // Storage port
  usdp_mem_if.store  mp
);

  usdp_byte_t mem_q [16];
  usdp_byte_t rdata_q;

  // Read before write: a same-address write shows one cycle later
  always_ff @(posedge clk) begin
    if (mp.we) begin
      mem_q[mp.waddr] <= mp.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_q <= `USDP_WIN_RESET;
    end else begin
      rdata_q <= mem_q[mp.raddr];
    end
  end

  assign mp.rdata = rdata_q;

endmodule

// File: verif/usdp_props.sv
// Port checker for the shadow data port
`timescale 1ns/1ps
`include "usdp_params.svh"
module usdp_props import usdp_pkg::*; (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Register port
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  // Line side
  input wire logic        uart_rx_valid,
  input wire usdp_byte_t  uart_rx_data,
  input wire usdp_byte_t  tx_data,
  input wire logic        uart_tx_valid,
  input wire logic        ir_tx_valid,
  input wire logic        tx_ready,
  input wire logic        rx_byte_available,
  input wire logic        tx_holding_empty,
  input wire logic        fifo_enable,
  input wire logic        ir_mode
);
  logic win;
  logic plain_rx;
  assign win = bus_addr >= `USDP_WIN_BASE && bus_addr <= `USDP_WIN_LAST && bus_addr[1:0] == 2'h0;
  // A control write in the same cycle may flush, so it is left out
  assign plain_rx = !fifo_enable && !ir_mode && uart_rx_valid && !bus_wr;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  property p_upper; bus_rd && win |=> bus_rdata[31:8] == 24'h00_0000; endproperty
  a_upper: assert property (p_upper) else $error("window upper bits not zero");
  property p_avail; plain_rx |=> rx_byte_available; endproperty
  a_avail: assert property (p_avail) else $error("byte available not raised");
  property p_rxdata; plain_rx ##1 bus_rd && win && !uart_rx_valid |=> bus_rdata[7:0] == $past(uart_rx_data, 2);
  endproperty
  a_rxdata: assert property (p_rxdata) else $error("latest byte not returned");
  property p_tx_holding_empty; !fifo_enable && bus_wr && win |=> !tx_holding_empty; endproperty
  a_tx_holding_empty: assert property (p_tx_holding_empty) else $error("holding empty not cleared");
  property p_hold; !fifo_enable && !ir_mode && bus_wr && win |=> uart_tx_valid && tx_data == $past(bus_wdata[7:0]);
  endproperty
  a_hold: assert property (p_hold) else $error("holding byte not replaced");
  property p_fthre; fifo_enable && bus_wr && win |=> !tx_holding_empty; endproperty
  a_fthre: assert property (p_fthre) else $error("fifo empty flag kept");
  property p_sel; !(uart_tx_valid && ir_mode) && !(ir_tx_valid && !ir_mode); endproperty
  a_sel: assert property (p_sel) else $error("wrong transmitter offered");
  property p_stand; uart_tx_valid && !tx_ready && !bus_wr |=> uart_tx_valid && $stable(tx_data); endproperty
  a_stand: assert property (p_stand) else $error("offered byte dropped");
  property p_keep; fifo_enable && rx_byte_available && !bus_rd && !bus_wr |=> rx_byte_available; endproperty
  a_keep: assert property (p_keep) else $error("fifo flag lost without read");
  c_fifo_rd: cover property (fifo_enable && bus_rd && win);
  c_uart_tx: cover property (uart_tx_valid && tx_ready);
  c_ir_tx: cover property (ir_tx_valid && tx_ready);
endmodule

bind usdp_top usdp_props i_props (.clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata,
  .uart_rx_valid, .uart_rx_data, .tx_data, .uart_tx_valid, .ir_tx_valid, .tx_ready,
  .rx_byte_available, .tx_holding_empty, .fifo_enable, .ir_mode);

// File: verif/usdp_remote.sv
// Far-end serial and infrared transceiver model
`timescale 1ns/1ps
module usdp_remote import usdp_pkg::*; (
  input  wire logic       clk,
  input  wire usdp_byte_t tx_data,
  input  wire logic       uart_tx_valid,
  input  wire logic       ir_tx_valid,
  input  wire logic       ir_mode,
  output logic            tx_ready,
  output logic            uart_rx_valid,
  output usdp_byte_t      uart_rx_data,
  output logic            ir_rx_valid,
  output usdp_byte_t      ir_rx_data
);
  logic       stall = 1'b0;
  usdp_byte_t got[$];
  initial begin
    uart_rx_valid = 1'b0;
    ir_rx_valid = 1'b0;
    uart_rx_data = 8'h00;
    ir_rx_data = 8'h00;
  end
  assign tx_ready = !stall;
  always @(posedge clk) begin
    if ((uart_tx_valid || ir_tx_valid) && tx_ready)
      got.push_back(tx_data);
  end
  // Idle lines show the inverse byte so stale data cannot pass as fresh
  task send(input usdp_byte_t b);
    @(posedge clk);
    if (ir_mode) begin
      ir_rx_valid <= 1'b1;
      ir_rx_data <= b;
    end else begin
      uart_rx_valid <= 1'b1;
      uart_rx_data <= b;
    end
    @(posedge clk);
    uart_rx_valid <= 1'b0;
    ir_rx_valid <= 1'b0;
    uart_rx_data <= ~b;
    ir_rx_data <= ~b;
  endtask
endmodule

// File: verif/usdp_top_test.sv
// Self-checking bench for the shadow data port
`timescale 1ns/1ps
`include "usdp_params.svh"
module usdp_top_test import usdp_pkg::*;;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [31:0] bus_addr = 32'h0000_0000;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic        bus_wr = 1'b0;
  logic        bus_rd = 1'b0;
  logic [31:0] bus_rdata;
  usdp_byte_t  uart_rx_data, ir_rx_data, tx_data;
  logic        uart_rx_valid, ir_rx_valid, uart_tx_valid, ir_tx_valid, tx_ready;
  logic        rx_byte_available, tx_holding_empty, fifo_enable, ir_mode, irq;
  int          err_count = 0;
  int          n_tests = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  usdp_top i_dut (.clk, .srst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .uart_rx_valid,
    .uart_rx_data, .ir_rx_valid, .ir_rx_data, .tx_data, .uart_tx_valid, .ir_tx_valid, .tx_ready,
    .rx_byte_available, .tx_holding_empty, .fifo_enable, .ir_mode, .irq);
  usdp_remote i_rem (.clk, .tx_data, .uart_tx_valid, .ir_tx_valid, .ir_mode, .tx_ready,
    .uart_rx_valid, .uart_rx_data, .ir_rx_valid, .ir_rx_data);

  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task give_verdict;
    if (err_count == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task wr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1 d = bus_rdata;
  endtask
  task wait_got(input int n);
    int k;
    for (k = 0; k < 300 && i_rem.got.size() < n; k++) @(posedge clk);
    if (k == 300) begin
      err_count++;
      give_verdict;
    end
  endtask

  task t_rx_plain;
    logic [31:0] d;
    rd(`USDP_OFS_LINE, d);
    check("line reset", d, 32'h0000_0020);
    rd(32'h5000_1200, d);
    check("unmapped", d, 32'h0000_0000);
    i_rem.send(8'h5A);
    rd(`USDP_OFS_WIN12, d);
    check("rx byte", d, 32'h0000_005A);
    check("avail after read", 32'(rx_byte_available), 32'h0000_0000);
    i_rem.send(8'h11);
    i_rem.send(8'h22);
    rd(`USDP_OFS_LINE, d);
    check("overrun", d & 32'h0000_0003, 32'h0000_0003);
    rd(`USDP_WIN_BASE, d);
    check("newest byte", d, 32'h0000_0022);
    // Read right behind the arrival, on the last alias
    fork
      i_rem.send(8'h66);
      begin
        @(posedge clk);
        rd(`USDP_WIN_BASE + 32'h0000_003C, d);
      end
    join
    check("quick read", d, 32'h0000_0066);
  endtask

  task t_tx_plain;
    logic [31:0] d;
    i_rem.got.delete();
    i_rem.stall <= 1'b1;
    check("empty before write", 32'(tx_holding_empty), 32'h0000_0001);
    wr(`USDP_OFS_WIN12, 32'h0000_00A1);
    check("empty cleared", 32'(tx_holding_empty), 32'h0000_0000);
    wr(`USDP_OFS_WIN12, 32'hFFFF_FFB2);
    check("replaced", 32'(tx_data), 32'h0000_00B2);
    check("ir idle", 32'(ir_tx_valid), 32'h0000_0000);
    check("uart offered", 32'(uart_tx_valid), 32'h0000_0001);
    i_rem.stall <= 1'b0;
    wait_got(1);
    rd(`USDP_OFS_LINE, d);
    check("empty again", d & 32'h0000_0020, 32'h0000_0020);
    check("sent count", 32'(i_rem.got.size()), 32'h0000_0001);
    check("sent byte", 32'(i_rem.got[0]), 32'h0000_00B2);
  endtask

  task t_irq;
    logic [31:0] d;
    wr(`USDP_OFS_IEN, 32'h0000_0001);
    i_rem.send(8'h77);
    rd(`USDP_OFS_IST, d);
    check("status", d & 32'h0000_0001, 32'h0000_0001);
    check("irq", 32'(irq), 32'h0000_0001);
    wr(`USDP_OFS_IEN, 32'h0000_0000);
    rd(`USDP_OFS_IST, d);
    check("irq masked", 32'(irq), 32'h0000_0000);
    wr(`USDP_OFS_IEN, 32'h0000_0001);
    wr(`USDP_OFS_ICLR, 32'h0000_0007);
    rd(`USDP_OFS_WIN12, d);
    check("irq cleared", 32'(irq), 32'h0000_0000);
  endtask

  task t_fifo;
    logic [31:0] d;
    int i;
    wr(`USDP_OFS_CTRL, 32'h0000_0001);
    check("fifo enabled", 32'(fifo_enable), 32'h0000_0001);
    for (i = 0; i < 17; i++) i_rem.send(8'h30 + 8'(i));
    rd(`USDP_OFS_LINE, d);
    check("fifo overrun", d & 32'h0000_0003, 32'h0000_0003);
    for (i = 0; i < 16; i++) begin
      rd(`USDP_WIN_BASE + 32'(4 * i), d);
      check("fifo head", d, 32'h0000_0030 + 32'(i));
    end
    check("fifo drained", 32'(rx_byte_available), 32'h0000_0000);
    i_rem.got.delete();
    i_rem.stall <= 1'b1;
    // Seventeen writes against a stalled line: the last one must vanish
    for (i = 0; i < 17; i++) wr(`USDP_WIN_BASE + 32'(4 * (i % 16)), 32'h0000_0040 + 32'(i));
    i_rem.stall <= 1'b0;
    wait_got(16);
    rd(`USDP_OFS_LINE, d);
    rd(`USDP_OFS_LINE, d);
    check("tx fifo count", 32'(i_rem.got.size()), 32'h0000_0010);
    for (i = 0; i < 16; i++) check("tx fifo byte", 32'(i_rem.got[i]), 32'h0000_0040 + 32'(i));
  endtask

  task t_ir;
    logic [31:0] d;
    wr(`USDP_OFS_CTRL, 32'h0000_0002);
    check("ir mode", 32'(ir_mode), 32'h0000_0001);
    check("fifo off", 32'(fifo_enable), 32'h0000_0000);
    i_rem.got.delete();
    i_rem.send(8'hC3);
    rd(`USDP_OFS_WIN12, d);
    check("ir rx", d, 32'h0000_00C3);
    wr(`USDP_OFS_WIN12, 32'h0000_003C);
    wait_got(1);
    check("ir tx", 32'(i_rem.got[0]), 32'h0000_003C);
  endtask

  initial begin
    repeat (3) @(posedge clk);
    srst <= 1'b0;
    t_rx_plain;
    t_tx_plain;
    t_irq;
    t_fifo;
    t_ir;
    give_verdict;
  end
endmodule
